// [hw/bsclk_defs.svh]
`ifndef BSCLK_DEFS_SVH
`define BSCLK_DEFS_SVH

// Register byte offsets
`define BSCLK_CTRL_OFF 8'h00
`define BSCLK_FREQ_OFF 8'h04
`define BSCLK_STATUS_OFF 8'h08
`define BSCLK_TXDATA_OFF 8'h0C
`define BSCLK_RXDATA_OFF 8'h10

// Control register fields
`define BSCLK_IDLY_BIT 0
`define BSCLK_ODLY_BIT 1
`define BSCLK_QDLY_BIT 2
`define BSCLK_PHASE_P_BIT 3
`define BSCLK_PHASE_N_BIT 4
`define BSCLK_FWD_UP_BIT 5
`define BSCLK_FWD_DOWN_BIT 6
`define BSCLK_PSHARE_BIT 7
`define BSCLK_NSHARE_BIT 8
`define BSCLK_SERIAL_BIT 9
`define BSCLK_RXINV_BIT 10
`define BSCLK_TXPH90_BIT 11
`define BSCLK_RXW8_BIT 12
`define BSCLK_TXW8_BIT 13
`define BSCLK_RXTYPE_LSB 14
`define BSCLK_RXTYPE_MSB 15
`define BSCLK_SRC_BIT 16
`define BSCLK_TUNE_BIT 17
`define BSCLK_DIV4_BIT 18
`define BSCLK_CTRL_MSB 18

// Reset values
`define BSCLK_CTRL_RST 19'h4301F
`define BSCLK_FREQ_RST 32'h01F401F4

// Status fields
`define BSCLK_ST_RXVALID_BIT 0
`define BSCLK_ST_TXBUSY_BIT 1
`define BSCLK_ST_MISMATCH_BIT 2
`define BSCLK_ST_OVERRUN_BIT 3

// Widths and dividers
`define BSCLK_WIDE_BITS 4'h8
`define BSCLK_NARROW_BITS 4'h4
`define BSCLK_DIV4 3'h4
`define BSCLK_DIV2 3'h2

`endif

// [hw/bsclk_pkg.sv]
package bsclk_pkg;

  typedef enum logic [1:0]
  {
    BSCLK_RX_DATA = 2'h0,
    BSCLK_RX_DATA_AND_CLOCK = 2'h1,
    BSCLK_RX_SERIAL = 2'h2
  } bsclk_rx_type_t;

  typedef enum logic [2:0]
  {
    BSCLK_TX_IDLE = 3'h1,
    BSCLK_TX_SHIFT = 3'h2,
    BSCLK_TX_LAST = 3'h4
  } bsclk_tx_state_t;

endpackage

// [hw/bsclk_top.sv]
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`include "bsclk_defs.svh"

// What this block does
// - Three tracking enables, default on, independent
// - Capture phase per path: shift 90 or 0 while auto tune is on
// - Separate up and down clock forwarding enables
// - Positive and negative nibble share direction settings
// - Write clock copy equals sample clock divided
// - Transmit phase setting delays transmitter output
// - Width settings size deserializer and serializer
// - Receive type: data, data-and-clock, or serial
// - Transmit one bit per master clock period
// - Capture source from strap or register bit
// - Serial mode captures on both master edges
// - Serial mode divides master for internal clocks
// - Non-serial mode captures with forwarded strobe unless receive type is serial
// - Optional inverter in forwarded receive clock path
// - Non-serial master clock only runs calibrator
// - Source select picks which master clock input
// - Auto tune targets phase, compensates delay mismatch
module bsclk_top
#(
  parameter logic SERIAL_STRAP = 1'b0,
  parameter logic SLICE_ZERO = 1'b1
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_strobe_in,
  input wire logic rx_data_rise_in,
  input wire logic rx_data_fall_in,
  output logic tx_data_out,
  output logic fifo_write_clock_copy_out,
  output logic forward_clock_up_out,
  output logic forward_clock_down_out,
  output logic pos_nibble_share_dir_out,
  output logic neg_nibble_share_dir_out,
  output logic pos_nibble_clock_out,
  output logic neg_nibble_clock_out,
  output logic input_delay_tracking_enable_out,
  output logic output_delay_tracking_enable_out,
  output logic third_delay_tracking_enable_out,
  output logic cal_shift90_p_out,
  output logic cal_shift90_n_out,
  output logic builtin_calibrator_run_out,
  output logic master_source_select_out
);

  logic [`BSCLK_CTRL_MSB:0] ctrl_ff;
  logic [31:0] freq_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] nxt_hrdata;
  logic [31:0] hrdata_ff;
  logic addr_ok;
  logic strobe_s1_ff, strobe_s2_ff, strobe_d_ff;
  logic rise_s1_ff, rise_s2_ff;
  logic fall_s1_ff, fall_s2_ff;
  logic serial_mode;
  logic sample_level;
  logic strobe_edge;
  logic strobe_rise;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_word_ff;
  logic rx_valid_ff;
  logic overrun_ff;
  logic word_done;
  logic rx_read;
  logic [3:0] rx_width;
  logic [2:0] div_val;
  logic [1:0] div_cnt_ff;
  logic wrclk_ff;
  logic period_tick;
  logic master_phase_ff;
  bsclk_pkg::bsclk_rx_type_t rx_type;
  bsclk_pkg::bsclk_tx_state_t tx_state_ff;
  logic [7:0] tx_shift_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_bit_ff;
  logic tx_bit_d_ff;
  logic tx_out_ff;
  logic tx_load;

  function automatic logic [3:0] width_of(input logic wide);
    width_of = wide ? `BSCLK_WIDE_BITS : `BSCLK_NARROW_BITS;
  endfunction

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a == `BSCLK_CTRL_OFF) || (a == `BSCLK_FREQ_OFF) || (a == `BSCLK_STATUS_OFF) ||
      (a == `BSCLK_TXDATA_OFF) || (a == `BSCLK_RXDATA_OFF);
  endfunction

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:8] == 24'h000000) && in_map(haddr[7:0]);

  always_comb
  begin
    nxt_hrdata = 32'h00000000;
    if (haddr[7:0] == `BSCLK_CTRL_OFF)
    begin
      nxt_hrdata = {13'h0000, ctrl_ff};
    end
    else if (haddr[7:0] == `BSCLK_FREQ_OFF)
    begin
      nxt_hrdata = freq_ff;
    end
    else if (haddr[7:0] == `BSCLK_STATUS_OFF)
    begin
      nxt_hrdata = {28'h0000000, overrun_ff, (ctrl_ff[`BSCLK_RXW8_BIT] != ctrl_ff[`BSCLK_DIV4_BIT]),
        (tx_state_ff != bsclk_pkg::BSCLK_TX_IDLE), rx_valid_ff};
    end
    else if (haddr[7:0] == `BSCLK_RXDATA_OFF)
    begin
      nxt_hrdata = {24'h000000, rx_word_ff};
    end
    else
    begin
      nxt_hrdata = 32'h00000000;
    end
  end

  // Read data is loaded at the address phase so it stands through the data phase
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      hrdata_ff <= 32'h00000000;
    end
    else if (addr_ok && !hwrite)
    begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  assign rx_read = addr_ok && !hwrite && (haddr[7:0] == `BSCLK_RXDATA_OFF);
  assign tx_load = wr_pend_ff && (wr_addr_ff == `BSCLK_TXDATA_OFF) && (tx_state_ff == bsclk_pkg::BSCLK_TX_IDLE);

  // Serial bit resets to the strap, software may override it later
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ctrl_ff <= `BSCLK_CTRL_RST;
      ctrl_ff[`BSCLK_SERIAL_BIT] <= SERIAL_STRAP;
    end
    else if (wr_pend_ff && (wr_addr_ff == `BSCLK_CTRL_OFF))
    begin
      ctrl_ff <= hwdata[`BSCLK_CTRL_MSB:0];
    end
  end

  // Held for software only; the block cannot measure the master rate itself
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      freq_ff <= `BSCLK_FREQ_RST;
    end
    else if (wr_pend_ff && (wr_addr_ff == `BSCLK_FREQ_OFF))
    begin
      freq_ff <= hwdata;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      strobe_s1_ff <= 1'b0;
      strobe_s2_ff <= 1'b0;
      strobe_d_ff <= 1'b0;
      rise_s1_ff <= 1'b0;
      rise_s2_ff <= 1'b0;
      fall_s1_ff <= 1'b0;
      fall_s2_ff <= 1'b0;
    end
    else
    begin
      strobe_s1_ff <= rx_strobe_in;
      strobe_s2_ff <= strobe_s1_ff;
      strobe_d_ff <= strobe_s2_ff;
      rise_s1_ff <= rx_data_rise_in;
      rise_s2_ff <= rise_s1_ff;
      fall_s1_ff <= rx_data_fall_in;
      fall_s2_ff <= fall_s1_ff;
    end
  end

  assign serial_mode = ctrl_ff[`BSCLK_SERIAL_BIT];
  assign rx_type = bsclk_pkg::bsclk_rx_type_t'(ctrl_ff[`BSCLK_RXTYPE_MSB:`BSCLK_RXTYPE_LSB]);
  assign rx_width = width_of(ctrl_ff[`BSCLK_RXW8_BIT]);
  assign div_val = ctrl_ff[`BSCLK_DIV4_BIT] ? `BSCLK_DIV4 : `BSCLK_DIV2;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      master_phase_ff <= 1'b0;
    end
    else
    begin
      master_phase_ff <= ~master_phase_ff;
    end
  end

  // Sample clock: regenerated master in serial mode, else the forwarded strobe
  assign sample_level = serial_mode ? master_phase_ff : (strobe_s2_ff ^ ctrl_ff[`BSCLK_RXINV_BIT]);
  assign strobe_edge = strobe_s2_ff ^ strobe_d_ff;
  assign strobe_rise = strobe_edge && (strobe_s2_ff ^ ctrl_ff[`BSCLK_RXINV_BIT]);
  assign period_tick = serial_mode ? 1'b1 : strobe_rise;

  // Words are taken from the shifted value, so the bit that ends the count is kept
  assign nxt_shift = (serial_mode || (rx_type == bsclk_pkg::BSCLK_RX_SERIAL)) ?
    {shift_ff[5:0], rise_s2_ff, fall_s2_ff} :
    (((rx_type == bsclk_pkg::BSCLK_RX_DATA_AND_CLOCK) && SLICE_ZERO) ? {shift_ff[6:0], strobe_s2_ff} :
    {shift_ff[6:0], rise_s2_ff});

  // Deserializer: two bits per master period in serial mode or serial receive type, one per strobe edge otherwise
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      shift_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
    end
    else if (serial_mode || (rx_type == bsclk_pkg::BSCLK_RX_SERIAL))
    begin
      shift_ff <= nxt_shift;
      bit_cnt_ff <= (bit_cnt_ff + 4'h2 >= rx_width) ? 4'h0 : bit_cnt_ff + 4'h2;
    end
    else if (strobe_edge)
    begin
      shift_ff <= nxt_shift;
      bit_cnt_ff <= (bit_cnt_ff + 4'h1 >= rx_width) ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  assign word_done = (serial_mode || (rx_type == bsclk_pkg::BSCLK_RX_SERIAL)) ?
    (bit_cnt_ff + 4'h2 >= rx_width) : (strobe_edge && (bit_cnt_ff + 4'h1 >= rx_width));

  // A word finished in the cycle it is read is kept: set wins
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rx_word_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (word_done)
      begin
        rx_word_ff <= ctrl_ff[`BSCLK_RXW8_BIT] ? nxt_shift : {4'h0, nxt_shift[3:0]};
        rx_valid_ff <= 1'b1;
        overrun_ff <= overrun_ff | (rx_valid_ff && !rx_read);
      end
      else if (rx_read)
      begin
        rx_valid_ff <= 1'b0;
        overrun_ff <= 1'b0;
      end
    end
  end

  // Write clock copy toggles every div/2 period ticks: master clocks in serial mode, strobe rises otherwise
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      div_cnt_ff <= 2'h0;
      wrclk_ff <= 1'b0;
    end
    else if (period_tick)
    begin
      if ({1'b0, div_cnt_ff} + 3'h1 >= (div_val >> 1))
      begin
        div_cnt_ff <= 2'h0;
        wrclk_ff <= ~wrclk_ff;
      end
      else
      begin
        div_cnt_ff <= div_cnt_ff + 2'h1;
      end
    end
  end

  // The fabric read clock must run at this same rate
  assign fifo_write_clock_copy_out = wrclk_ff;
  assign forward_clock_up_out = ctrl_ff[`BSCLK_FWD_UP_BIT] & sample_level;
  assign forward_clock_down_out = ctrl_ff[`BSCLK_FWD_DOWN_BIT] & sample_level;
  assign pos_nibble_share_dir_out = ctrl_ff[`BSCLK_PSHARE_BIT];
  assign neg_nibble_share_dir_out = ctrl_ff[`BSCLK_NSHARE_BIT];
  assign pos_nibble_clock_out = ctrl_ff[`BSCLK_PSHARE_BIT] & sample_level;
  assign neg_nibble_clock_out = ctrl_ff[`BSCLK_NSHARE_BIT] & ~sample_level;
  assign input_delay_tracking_enable_out = ctrl_ff[`BSCLK_IDLY_BIT];
  assign output_delay_tracking_enable_out = ctrl_ff[`BSCLK_ODLY_BIT];
  assign third_delay_tracking_enable_out = ctrl_ff[`BSCLK_QDLY_BIT];
  assign cal_shift90_p_out = ctrl_ff[`BSCLK_TUNE_BIT] & ctrl_ff[`BSCLK_PHASE_P_BIT];
  assign cal_shift90_n_out = ctrl_ff[`BSCLK_TUNE_BIT] & ctrl_ff[`BSCLK_PHASE_N_BIT];
  assign builtin_calibrator_run_out = ctrl_ff[`BSCLK_TUNE_BIT] & ~serial_mode;
  assign master_source_select_out = ctrl_ff[`BSCLK_SRC_BIT];

  // Serializer: one bit per master clock period
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      tx_state_ff <= bsclk_pkg::BSCLK_TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      tx_bit_ff <= 1'b0;
    end
    else
    begin
      case (tx_state_ff)
        bsclk_pkg::BSCLK_TX_IDLE:
        begin
          if (tx_load)
          begin
            tx_shift_ff <= ctrl_ff[`BSCLK_TXW8_BIT] ? hwdata[7:0] : {hwdata[3:0], 4'h0};
            tx_cnt_ff <= width_of(ctrl_ff[`BSCLK_TXW8_BIT]) - 4'h1;
            tx_state_ff <= bsclk_pkg::BSCLK_TX_SHIFT;
          end
        end
        bsclk_pkg::BSCLK_TX_SHIFT:
        begin
          tx_bit_ff <= tx_shift_ff[7];
          tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
          tx_cnt_ff <= tx_cnt_ff - 4'h1;
          if (tx_cnt_ff == 4'h0)
          begin
            tx_state_ff <= bsclk_pkg::BSCLK_TX_LAST;
          end
        end
        bsclk_pkg::BSCLK_TX_LAST:
        begin
          // Line idles low so the last bit stands one clock only
          tx_bit_ff <= 1'b0;
          tx_state_ff <= bsclk_pkg::BSCLK_TX_IDLE;
        end
        default:
        begin
          tx_state_ff <= bsclk_pkg::BSCLK_TX_IDLE;
        end
      endcase
    end
  end

  // Quarter-bit shift cannot be made on one clock; a whole-cycle delay stands in
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      tx_bit_d_ff <= 1'b0;
      tx_out_ff <= 1'b0;
    end
    else
    begin
      tx_bit_d_ff <= tx_bit_ff;
      tx_out_ff <= ctrl_ff[`BSCLK_TXPH90_BIT] ? tx_bit_d_ff : tx_bit_ff;
    end
  end

  assign tx_data_out = tx_out_ff;

endmodule

// [verification/bsclk_bench.sv]
`timescale 1ns/10ps
`include "bsclk_defs.svh"
`define CHK(nm, e, a) begin samples_checked++; if ((e) !== (a)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module bsclk_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic ser = 1'b0;
  logic [7:0] word = 8'h0;
  logic [3:0] nbits = 4'h8;
  logic hreadyout, hresp, tx_data_out, strobe, rise, fall, fwd_up, fwd_dn, w8, ph, wclk;
  logic [31:0] hrdata, rd;
  logic [15:0] seed = 16'h0040;
  logic [7:0] exp, got;
  int k;
  int error_cnt = 0;
  int samples_checked = 0;
  bsclk_top dut_u (.clock_in, .rst_in, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_strobe_in(strobe), .rx_data_rise_in(rise),
    .rx_data_fall_in(fall), .tx_data_out, .fifo_write_clock_copy_out(wclk), .forward_clock_up_out(fwd_up),
    .forward_clock_down_out(fwd_dn), .pos_nibble_share_dir_out(), .neg_nibble_share_dir_out(),
    .pos_nibble_clock_out(), .neg_nibble_clock_out(), .input_delay_tracking_enable_out(),
    .output_delay_tracking_enable_out(), .third_delay_tracking_enable_out(), .cal_shift90_p_out(),
    .cal_shift90_n_out(), .builtin_calibrator_run_out(), .master_source_select_out());
  bsclk_src_model src_u (.clock_in, .go_in(go), .serial_in(ser), .word_in(word), .nbits_in(nbits),
    .strobe_out(strobe), .rise_out(rise), .fall_out(fall));
  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rx_get;
    k = 0;
    do
    begin
      bus(1'b0, `BSCLK_STATUS_OFF, 32'h0);
      k++;
    end
    while (rd[0] !== 1'b1 && k < 200);
    bus(1'b0, `BSCLK_RXDATA_OFF, 32'h0);
  endtask
  task complete_run;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clock_in);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    bus(1'b0, `BSCLK_CTRL_OFF, 32'h0);
    `CHK("ctrl reset", 32'h0004301F, rd)
    bus(1'b0, `BSCLK_FREQ_OFF, 32'h0);
    `CHK("freq reset", 32'h01F401F4, rd)
    bus(1'b0, 8'h14, 32'h0);
    `CHK("unmapped read", 32'h01F401F4, rd)
    bus(1'b1, `BSCLK_FREQ_OFF, 32'h00280028);
    bus(1'b0, `BSCLK_FREQ_OFF, 32'h0);
    `CHK("freq", 32'h00280028, rd)
    for (int i = 0; i < 2; i++)
    begin
      w8 = !i[0];
      seed = lfsr(seed);
      exp = seed[7:0] & (w8 ? 8'hFF : 8'h0F);
      bus(1'b1, `BSCLK_CTRL_OFF, w8 ? 32'h00041007 : 32'h00000007);
      @(posedge clock_in);
      word <= w8 ? exp : {exp[3:0], 4'h0};
      nbits <= w8 ? 4'h8 : 4'h4;
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      rx_get();
      `CHK("rx strobe word", {24'h0, exp}, rd)
    end
    for (int x = 0; x < 2; x++)
    begin
      bus(1'b1, `BSCLK_CTRL_OFF, x[0] ? 32'h00000427 : 32'h00000027);
      repeat (4) @(posedge clock_in);
      #1;
      `CHK("fwd up", strobe ^ x[0], fwd_up)
      `CHK("fwd down", 1'b0, fwd_dn)
    end
    for (int i = 0; i < 4; i++)
    begin
      w8 = i[0];
      ph = i[1];
      seed = lfsr(seed);
      exp = (seed[7:0] | (w8 ? 8'h80 : 8'h08)) & (w8 ? 8'hFF : 8'h0F);
      bus(1'b1, `BSCLK_CTRL_OFF, 32'h00000007 | (w8 ? 32'h00002000 : 32'h0) | (ph ? 32'h00000800 : 32'h0));
      bus(1'b1, `BSCLK_TXDATA_OFF, {24'h0, exp});
      k = 0;
      #1;
      while (tx_data_out !== 1'b1 && k < 20)
      begin
        @(posedge clock_in);
        #1;
        k++;
      end
      `CHK("tx first bit delay", ph ? 3 : 2, k)
      got = 8'h0;
      for (int b = 0; b < (w8 ? 8 : 4); b++)
      begin
        got = {got[6:0], tx_data_out};
        @(posedge clock_in);
        #1;
      end
      `CHK("tx word", exp, got)
    end
    // Serial capture runs freely, so the first word may hold bits from before the switch
    ser <= 1'b1;
    word <= 8'h01;
    for (int i = 0; i < 2; i++)
    begin
      w8 = i[0];
      bus(1'b1, `BSCLK_CTRL_OFF, w8 ? 32'h00041207 : 32'h00000207);
      rx_get();
      rx_get();
      `CHK("rx serial word", w8 ? 32'h000000AA : 32'h0000000A, rd)
      // The fabric read clock must match this period: one write per divide of master clocks
      do
      begin
        @(posedge clock_in);
        #1;
      end
      while (wclk !== 1'b0);
      do
      begin
        @(posedge clock_in);
        #1;
      end
      while (wclk !== 1'b1);
      k = 0;
      do
      begin
        @(posedge clock_in);
        #1;
        k++;
      end
      while (wclk !== 1'b0 && k < 20);
      do
      begin
        @(posedge clock_in);
        #1;
        k++;
      end
      while (wclk !== 1'b1 && k < 20);
      `CHK("write clock period", w8 ? 4 : 2, k)
    end
    ser <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      bus(1'b1, `BSCLK_CTRL_OFF, {13'h0, seed[2:0], lfsr(seed)});
      bus(1'b0, `BSCLK_CTRL_OFF, 32'h0);
      `CHK("ctrl", {13'h0, seed[2:0], lfsr(seed)}, rd)
    end
    complete_run();
  end
endmodule

// [verification/bsclk_chk.sv]
`timescale 1ns/10ps
`include "bsclk_defs.svh"
module bsclk_chk
#(
  parameter logic SERIAL_STRAP = 1'b0
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fifo_write_clock_copy_out,
  input wire logic forward_clock_up_out,
  input wire logic forward_clock_down_out,
  input wire logic pos_nibble_share_dir_out,
  input wire logic neg_nibble_share_dir_out,
  input wire logic pos_nibble_clock_out,
  input wire logic neg_nibble_clock_out,
  input wire logic input_delay_tracking_enable_out,
  input wire logic output_delay_tracking_enable_out,
  input wire logic third_delay_tracking_enable_out,
  input wire logic cal_shift90_p_out,
  input wire logic cal_shift90_n_out,
  input wire logic builtin_calibrator_run_out,
  input wire logic master_source_select_out
);
  // Shadow of the control word, rebuilt from bus writes only
  logic wr_ff;
  logic [18:0] ctrl_ff;
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      wr_ff <= 1'b0;
    else if (hready)
      wr_ff <= hsel && htrans[1] && hwrite && (haddr == 32'h0);
  end
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      ctrl_ff <= `BSCLK_CTRL_RST | {9'h0, SERIAL_STRAP, 9'h0};
    else if (wr_ff && hready)
      ctrl_ff <= hwdata[18:0];
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence seq_reset_done;
    $fell(rst_in);
  endsequence
  // Serial capture with divide by two; held three cycles so a mode change settles
  sequence seq_serial_div2;
    ctrl_ff[9] && !ctrl_ff[18];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_TRACK_RST: assert property (seq_reset_done |-> input_delay_tracking_enable_out &&
    output_delay_tracking_enable_out && third_delay_tracking_enable_out) else $error("tracking off after reset");
  AST_TRACK: assert property ({third_delay_tracking_enable_out, output_delay_tracking_enable_out,
    input_delay_tracking_enable_out} == ctrl_ff[2:0]) else $error("tracking enable mismatch");
  AST_PHASE: assert property (cal_shift90_p_out == (ctrl_ff[17] && ctrl_ff[3]) &&
    cal_shift90_n_out == (ctrl_ff[17] && ctrl_ff[4])) else $error("capture phase mismatch");
  AST_FWD: assert property (!(forward_clock_up_out && !ctrl_ff[5]) &&
    !(forward_clock_down_out && !ctrl_ff[6])) else $error("clock forwarded while disabled");
  AST_SHARE: assert property (pos_nibble_share_dir_out == ctrl_ff[7] && neg_nibble_share_dir_out == ctrl_ff[8] &&
    !(pos_nibble_clock_out && !ctrl_ff[7]) &&
    !(neg_nibble_clock_out && !ctrl_ff[8])) else $error("nibble share mismatch");
  AST_CALRUN: assert property (builtin_calibrator_run_out == (ctrl_ff[17] && !ctrl_ff[9]))
    else $error("calibrator run mismatch");
  AST_SRC: assert property (master_source_select_out == ctrl_ff[16])
    else $error("source select mismatch");
  AST_WRCLK: assert property (seq_serial_div2 [*3] |-> $changed(fifo_write_clock_copy_out))
    else $error("write clock copy not toggling each clock");
endmodule
bind bsclk_top bsclk_chk #(.SERIAL_STRAP(SERIAL_STRAP)) chk_u (.clock_in, .rst_in, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .fifo_write_clock_copy_out, .forward_clock_up_out,
  .forward_clock_down_out, .pos_nibble_share_dir_out, .neg_nibble_share_dir_out, .pos_nibble_clock_out,
  .neg_nibble_clock_out,
  .input_delay_tracking_enable_out, .output_delay_tracking_enable_out, .third_delay_tracking_enable_out,
  .cal_shift90_p_out, .cal_shift90_n_out, .builtin_calibrator_run_out, .master_source_select_out);

// [verification/bsclk_src_model.sv]
`timescale 1ns/10ps
module bsclk_src_model
(
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic serial_in,
  input wire logic [7:0] word_in,
  input wire logic [3:0] nbits_in,
  output logic strobe_out,
  output logic rise_out,
  output logic fall_out
);
  logic [7:0] sh_ff = 8'h0;
  logic [3:0] left_ff = 4'h0;
  logic [1:0] ph_ff = 2'h0;
  initial
  begin
    strobe_out = 1'b0;
    rise_out = 1'b0;
    fall_out = 1'b1;
  end
  always @(posedge clock_in)
  begin
    if (serial_in)
    begin
      rise_out <= word_in[0];
      fall_out <= !word_in[0];
    end
    else if (go_in)
    begin
      sh_ff <= word_in;
      left_ff <= nbits_in;
      ph_ff <= 2'h0;
    end
    else if (left_ff != 4'h0)
    begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h0)
      begin
        rise_out <= sh_ff[7];
        sh_ff <= sh_ff << 1;
      end
      if (ph_ff == 2'h2)
        strobe_out <= !strobe_out;
      // Data held two cycles past the strobe edge to cover synchroniser skew
      if (ph_ff == 2'h3)
        left_ff <= left_ff - 4'h1;
    end
    else
    begin
      rise_out <= !rise_out;
      fall_out <= !fall_out;
    end
  end
endmodule
